// ==== core/irtx_pkg.sv ====
// constants and types for the infrared transmit scatter/gather dma channel
package irtx_pkg;
  localparam int unsigned BLOCK_BYTES = 64;
  localparam logic [5:0] OFS_CSR = 6'h00;
  localparam logic [5:0] OFS_CNT = 6'h04;
  localparam logic [5:0] OFS_BASE = 6'h08;
  localparam logic [5:0] OFS_BUF = 6'h0c;
  localparam logic [5:0] OFS_LEN = 6'h14;
  localparam logic [5:0] OFS_STF = 6'h17;
  localparam logic [5:0] OFS_TMR = 6'h1a;
  // control/status bit positions
  localparam int unsigned B_CHEN = 0;
  localparam int unsigned B_DIR = 4;
  localparam int unsigned B_TMRE = 5;
  localparam int unsigned B_INTE = 6;
  localparam int unsigned B_PREQ = 8;
  localparam int unsigned B_HALT = 16;
  localparam int unsigned B_ACTV = 17;
  localparam int unsigned B_PACK = 18;
  localparam int unsigned B_WM = 19;
  localparam int unsigned B_IDLE_TIMEOUT_FLAG = 20;
  localparam int unsigned B_EOD = 21;
  localparam int unsigned B_DSCER = 23;
  localparam int unsigned B_PCI_TARGET_ABORT_FLAG = 25;
  localparam int unsigned B_PCI_MASTER_ABORT_FLAG = 26;
  // descriptor command/status byte bits
  localparam int unsigned C_INT = 0;
  localparam int unsigned C_PULSE = 1;
  localparam int unsigned C_UNDER = 2;
  localparam int unsigned C_EOF = 6;
  localparam int unsigned C_DONE = 7;
  localparam logic [7:0] C_RSVD_MASK = 8'h38;
  // descriptor layout in memory: word 0 pointer, word 1 length and command/status
  localparam logic [31:0] DESC_WORD1 = 32'h0000_0004;
  localparam logic [31:0] DESC_BYTES = 32'h0000_0008;
  localparam logic [3:0] BE_ALL = 4'hf;
  localparam logic [3:0] BE_STATUS = 4'h8;
  localparam int unsigned FIFO_DEPTH = 4;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_FETCH0 = 4'b0001,
    ST_FETCH1 = 4'b0010,
    ST_CHECK = 4'b0011,
    ST_READ = 4'b0100,
    ST_PUSH = 4'b0101,
    ST_WBACK = 4'b0110,
    ST_NEXT = 4'b0111,
    ST_PAUSED = 4'b1000
  } irtx_state_e;

  typedef struct packed {
    logic valid;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } irtx_mem_req_s;

  typedef struct packed {
    logic eof;
    logic pulse;
    logic [7:0] data;
  } irtx_byte_s;

  typedef struct packed {
    irtx_state_e st;
    logic chen, tmre, inte, preq;
    logic halt, active, pack, wm, idle_timeout_flag, eod, dscer, pci_target_abort_flag, pci_master_abort_flag;
    logic [7:0] cnt;
    logic [31:0] base, ptr, buf_addr;
    logic [15:0] len;
    logic [7:0] stf;
    logic [15:0] tmr_prog, tmr_live;
    logic underrun, in_frame;
    logic [7:0] byte_q;
    logic [31:0] rdata;
    irtx_mem_req_s mem;
  } irtx_regs_s;
endpackage : irtx_pkg

// ==== core/irtx_dma.sv ====
// infrared transmit scatter/gather dma channel with its output fifo
`timescale 1ns/1ps

module irtx_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 4
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp, rp;
    logic [AW:0] fill;
  } irtx_fifo_s;
  irtx_fifo_s s_q, s_d;
  logic push, pop;

  // fill is one bit wider than the pointers so a full fifo is told apart from empty
  assign o_in_ready = (s_q.fill != (AW+1)'(DEPTH));
  assign o_out_valid = (s_q.fill != '0);
  assign o_out_data = s_q.mem[s_q.rp];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = i_in_data;
      s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
    end
    s_d.fill = s_q.fill + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : irtx_fifo

module irtx_dma (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // io register port; base comes from the function's configuration register
  input wire logic [31:0] i_io_base,
  input wire logic [31:0] i_io_addr,
  input wire logic i_io_rd,
  input wire logic i_io_wr,
  input wire logic [3:0] i_io_be,
  input wire logic [31:0] i_io_wdata,
  output logic o_io_hit,
  output logic [31:0] o_io_rdata,
  // bus master request towards host memory
  output irtx_pkg::irtx_mem_req_s o_mem,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  input wire logic i_mem_target_abort,
  input wire logic i_mem_master_abort,
  // byte stream to the infrared serial controller
  output logic o_sc_valid,
  input wire logic i_sc_ready,
  output irtx_pkg::irtx_byte_s o_sc_byte,
  output logic o_sc_irq
);
  irtx_pkg::irtx_regs_s r_q, r_d;
  logic [31:0] ofs;
  logic hit;
  logic [3:0] widx;
  logic wr_csr, wr_cnt, wr_base, wr_tmr;
  logic [31:0] w1c;
  logic fifo_ready, fifo_valid, push_ok;
  irtx_pkg::irtx_byte_s push_byte;
  logic sc_pop;
  logic bus_err;
  logic [7:0] wb_status;

  function automatic logic word_is(input logic [3:0] idx, input logic [5:0] ofs_c);
    word_is = (idx == ofs_c[5:2]);
  endfunction : word_is

  // byte-addressed block, dword decoded; everything outside 64 bytes is not ours
  assign ofs = i_io_addr - i_io_base;
  assign hit = (i_io_addr >= i_io_base) && (ofs < 32'(irtx_pkg::BLOCK_BYTES));
  assign widx = ofs[5:2];
  assign o_io_hit = hit && (i_io_rd || i_io_wr);
  assign o_io_rdata = r_q.rdata;
  assign o_mem = r_q.mem;

  always_comb begin
    wr_csr = 1'b0;
    wr_cnt = 1'b0;
    wr_base = 1'b0;
    wr_tmr = 1'b0;
    if (hit && i_io_wr) begin
      if (word_is(widx, irtx_pkg::OFS_CSR)) begin
        wr_csr = 1'b1;
      end else if (word_is(widx, irtx_pkg::OFS_CNT)) begin
        wr_cnt = i_io_be[0];
      end else if (word_is(widx, irtx_pkg::OFS_BASE)) begin
        wr_base = 1'b1;
      end else if (word_is(widx, irtx_pkg::OFS_TMR)) begin
        wr_tmr = i_io_be[2] || i_io_be[3];
      end
    end
  end

  // write-one-to-clear mask, only over enabled byte lanes
  always_comb begin
    w1c = '0;
    if (wr_csr) begin
      w1c = i_io_wdata & {{8{i_io_be[3]}}, {8{i_io_be[2]}}, {8{i_io_be[1]}}, {8{i_io_be[0]}}};
    end
  end

  assign bus_err = r_q.mem.valid && (i_mem_target_abort || i_mem_master_abort);
  assign push_byte.data = r_q.byte_q;
  assign push_byte.eof = r_q.stf[irtx_pkg::C_EOF] && (r_q.len == 16'h0001);
  assign push_byte.pulse = push_byte.eof && r_q.stf[irtx_pkg::C_PULSE];
  assign push_ok = (r_q.st == irtx_pkg::ST_PUSH) && fifo_ready;
  assign sc_pop = fifo_valid && i_sc_ready;
  assign o_sc_valid = fifo_valid;

  // pulse cleared once the frame went out, done always set, underrun recorded
  always_comb begin
    wb_status = r_q.stf;
    wb_status[irtx_pkg::C_DONE] = 1'b1;
    wb_status[irtx_pkg::C_UNDER] = r_q.underrun;
    if (r_q.stf[irtx_pkg::C_EOF]) begin
      wb_status[irtx_pkg::C_PULSE] = 1'b0;
    end
  end

  irtx_fifo #(
    .WIDTH($bits(irtx_pkg::irtx_byte_s)),
    .DEPTH(irtx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(r_q.st == irtx_pkg::ST_PUSH),
    .o_in_ready(fifo_ready),
    .i_in_data(push_byte),
    .o_out_valid(fifo_valid),
    .i_out_ready(i_sc_ready),
    .o_out_data(o_sc_byte)
  );

  // interrupt line to the serial controller's interrupt logic
  assign o_sc_irq = r_q.inte && (r_q.wm || r_q.idle_timeout_flag || r_q.eod || r_q.dscer
                                 || r_q.pci_target_abort_flag || r_q.pci_master_abort_flag);

  always_comb begin
    r_d = r_q;

    // register reads; unlisted words and reserved bits are zero
    if (hit && i_io_rd) begin
      r_d.rdata = '0;
      if (word_is(widx, irtx_pkg::OFS_CSR)) begin
        r_d.rdata[irtx_pkg::B_CHEN] = r_q.chen;
        r_d.rdata[irtx_pkg::B_DIR] = 1'b1;
        r_d.rdata[irtx_pkg::B_TMRE] = r_q.tmre;
        r_d.rdata[irtx_pkg::B_INTE] = r_q.inte;
        r_d.rdata[irtx_pkg::B_PREQ] = r_q.preq;
        r_d.rdata[irtx_pkg::B_HALT] = r_q.halt;
        r_d.rdata[irtx_pkg::B_ACTV] = r_q.active;
        r_d.rdata[irtx_pkg::B_PACK] = r_q.pack;
        r_d.rdata[irtx_pkg::B_WM] = r_q.wm;
        r_d.rdata[irtx_pkg::B_IDLE_TIMEOUT_FLAG] = r_q.idle_timeout_flag;
        r_d.rdata[irtx_pkg::B_EOD] = r_q.eod;
        r_d.rdata[irtx_pkg::B_DSCER] = r_q.dscer;
        r_d.rdata[irtx_pkg::B_PCI_TARGET_ABORT_FLAG] = r_q.pci_target_abort_flag;
        r_d.rdata[irtx_pkg::B_PCI_MASTER_ABORT_FLAG] = r_q.pci_master_abort_flag;
      end else if (word_is(widx, irtx_pkg::OFS_CNT)) begin
        r_d.rdata[7:0] = r_q.cnt;
      end else if (word_is(widx, irtx_pkg::OFS_BASE)) begin
        r_d.rdata = r_q.base;
      end else if (word_is(widx, irtx_pkg::OFS_BUF)) begin
        r_d.rdata = r_q.buf_addr;
      end else if (word_is(widx, irtx_pkg::OFS_LEN)) begin
        r_d.rdata = {r_q.stf, 8'h00, r_q.len};
      end else if (word_is(widx, irtx_pkg::OFS_TMR)) begin
        r_d.rdata[31:16] = r_q.tmre ? r_q.tmr_live : r_q.tmr_prog;
      end
    end

    // software controls
    if (wr_csr && i_io_be[0]) begin
      r_d.chen = i_io_wdata[irtx_pkg::B_CHEN];
      r_d.tmre = i_io_wdata[irtx_pkg::B_TMRE];
      r_d.inte = i_io_wdata[irtx_pkg::B_INTE];
    end
    if (wr_csr && i_io_be[1]) begin
      r_d.preq = i_io_wdata[irtx_pkg::B_PREQ];
    end
    if (wr_cnt) begin
      r_d.cnt = i_io_wdata[7:0];
    end
    // table base doubles as the walk pointer's start point
    if (wr_base) begin
      r_d.base = i_io_wdata;
      r_d.ptr = i_io_wdata;
    end

    // write-one clears; hardware sets below override these
    r_d.halt = r_q.halt && !w1c[irtx_pkg::B_HALT];
    r_d.wm = r_q.wm && !w1c[irtx_pkg::B_WM];
    r_d.idle_timeout_flag = r_q.idle_timeout_flag && !w1c[irtx_pkg::B_IDLE_TIMEOUT_FLAG];
    r_d.eod = r_q.eod && !w1c[irtx_pkg::B_EOD];
    r_d.dscer = r_q.dscer && !w1c[irtx_pkg::B_DSCER];
    r_d.pci_target_abort_flag = r_q.pci_target_abort_flag && !w1c[irtx_pkg::B_PCI_TARGET_ABORT_FLAG];
    r_d.pci_master_abort_flag = r_q.pci_master_abort_flag && !w1c[irtx_pkg::B_PCI_MASTER_ABORT_FLAG];

    // idle timer; write wins over the per-cycle count
    if (wr_tmr) begin
      if (i_io_be[2]) begin
        r_d.tmr_prog[7:0] = i_io_wdata[23:16];
      end
      if (i_io_be[3]) begin
        r_d.tmr_prog[15:8] = i_io_wdata[31:24];
      end
      r_d.tmr_live = r_d.tmr_prog;
    end else if (r_q.tmre && push_ok) begin
      r_d.tmr_live = r_q.tmr_prog;
    end else if (r_q.tmre && r_q.tmr_live != 16'h0000) begin
      r_d.tmr_live = r_q.tmr_live - 16'h0001;
      if (r_q.tmr_live == 16'h0001) begin
        r_d.idle_timeout_flag = 1'b1;
      end
    end

    // underrun: controller wants a byte mid-frame and the fifo is dry
    if (sc_pop && o_sc_byte.eof) begin
      r_d.in_frame = 1'b0;
    end
    if (push_ok) begin
      r_d.in_frame = 1'b1;
    end
    if (r_q.in_frame && !fifo_valid && i_sc_ready) begin
      r_d.underrun = 1'b1;
    end

    // memory completion clears the request
    if (r_q.mem.valid && (i_mem_ack || bus_err)) begin
      r_d.mem.valid = 1'b0;
    end
    if (bus_err) begin
      r_d.pci_target_abort_flag = r_d.pci_target_abort_flag || i_mem_target_abort;
      r_d.pci_master_abort_flag = r_d.pci_master_abort_flag || i_mem_master_abort;
      r_d.halt = 1'b1;
      r_d.active = 1'b0;
      r_d.st = irtx_pkg::ST_IDLE;
    end else begin
      case (r_q.st)
        irtx_pkg::ST_IDLE: begin
          // halted channel stays put until software clears the halt
          if (r_q.chen && !r_q.halt && r_q.cnt != 8'h00) begin
            r_d.mem = '{1'b1, 1'b0, r_q.ptr, 32'h0000_0000, irtx_pkg::BE_ALL};
            r_d.st = irtx_pkg::ST_FETCH0;
          end
        end
        irtx_pkg::ST_FETCH0: begin
          if (i_mem_ack) begin
            r_d.buf_addr = i_mem_rdata;
            r_d.mem = '{1'b1, 1'b0, r_q.ptr + irtx_pkg::DESC_WORD1, 32'h0000_0000,
                        irtx_pkg::BE_ALL};
            r_d.st = irtx_pkg::ST_FETCH1;
          end
        end
        irtx_pkg::ST_FETCH1: begin
          if (i_mem_ack) begin
            r_d.len = i_mem_rdata[15:0];
            r_d.stf = i_mem_rdata[31:24];
            r_d.underrun = 1'b0;
            r_d.st = irtx_pkg::ST_CHECK;
          end
        end
        irtx_pkg::ST_CHECK: begin
          // a descriptor already marked done or with reserved bits set is refused
          if ((r_q.stf & irtx_pkg::C_RSVD_MASK) != 8'h00 || r_q.stf[irtx_pkg::C_DONE]) begin
            r_d.dscer = 1'b1;
            r_d.halt = 1'b1;
            r_d.active = 1'b0;
            r_d.st = irtx_pkg::ST_IDLE;
          end else if (r_q.stf[irtx_pkg::C_INT]) begin
            r_d.wm = 1'b1;
            r_d.st = irtx_pkg::ST_READ;
          end else begin
            r_d.st = irtx_pkg::ST_READ;
          end
        end
        irtx_pkg::ST_READ: begin
          // clearing enable stops new byte reads here without losing position; a drained descriptor still writes back
          if (r_q.len == 16'h0000) begin
            r_d.mem = '{1'b1, 1'b1, r_q.ptr + irtx_pkg::DESC_WORD1, {wb_status, 24'h00_0000},
                        irtx_pkg::BE_STATUS};
            r_d.stf = wb_status;
            r_d.st = irtx_pkg::ST_WBACK;
          end else if (r_q.chen && !r_q.mem.valid) begin
            r_d.mem = '{1'b1, 1'b0, {r_q.buf_addr[31:2], 2'b00}, 32'h0000_0000,
                        irtx_pkg::BE_ALL};
          end else if (r_q.mem.valid && i_mem_ack) begin
            r_d.byte_q = i_mem_rdata[{r_q.buf_addr[1:0], 3'b000} +: 8];
            r_d.st = irtx_pkg::ST_PUSH;
          end
        end
        irtx_pkg::ST_PUSH: begin
          // fifo back-pressure holds the engine here
          if (fifo_ready) begin
            r_d.active = 1'b1;
            r_d.buf_addr = r_q.buf_addr + 32'h0000_0001;
            r_d.len = r_q.len - 16'h0001;
            r_d.st = irtx_pkg::ST_READ;
          end
        end
        irtx_pkg::ST_WBACK: begin
          if (i_mem_ack) begin
            r_d.cnt = r_q.cnt - 8'h01;
            r_d.ptr = r_q.ptr + irtx_pkg::DESC_BYTES;
            if (r_q.stf[irtx_pkg::C_EOF]) begin
              r_d.wm = 1'b1;
            end
            r_d.st = irtx_pkg::ST_NEXT;
          end
        end
        irtx_pkg::ST_NEXT: begin
          if (r_q.cnt == 8'h00) begin
            r_d.eod = 1'b1;
            r_d.halt = 1'b1;
            r_d.active = 1'b0;
            r_d.st = irtx_pkg::ST_IDLE;
          end else if (r_q.preq && r_q.stf[irtx_pkg::C_EOF]) begin
            r_d.pack = 1'b1;
            r_d.st = irtx_pkg::ST_PAUSED;
          end else if (r_q.chen) begin
            r_d.mem = '{1'b1, 1'b0, r_q.ptr, 32'h0000_0000, irtx_pkg::BE_ALL};
            r_d.st = irtx_pkg::ST_FETCH0;
          end
        end
        irtx_pkg::ST_PAUSED: begin
          if (!r_q.preq) begin
            r_d.pack = 1'b0;
            r_d.st = irtx_pkg::ST_NEXT;
          end
        end
        default: begin
          r_d.st = irtx_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end
endmodule : irtx_dma

// ==== tb/irtx_dma_properties.sv ====
// port-level concurrent checks for the transmit dma channel
`timescale 1ns/1ps
module irtx_dma_properties (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [31:0] i_io_base,
  input wire logic [31:0] i_io_addr,
  input wire logic i_io_rd,
  input wire logic i_io_wr,
  input wire logic [3:0] i_io_be,
  input wire logic [31:0] i_io_wdata,
  input wire logic o_io_hit,
  input wire logic [31:0] o_io_rdata,
  input wire irtx_pkg::irtx_mem_req_s o_mem,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  input wire logic i_mem_target_abort,
  input wire logic i_mem_master_abort,
  input wire logic o_sc_valid,
  input wire logic i_sc_ready,
  input wire irtx_pkg::irtx_byte_s o_sc_byte,
  input wire logic o_sc_irq
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  logic [31:0] ofs;
  logic in_blk;
  logic rd_csr;
  logic wrote_q;
  assign ofs = i_io_addr - i_io_base;
  assign in_blk = (i_io_addr >= i_io_base) && (ofs < 32'h0000_0040);
  assign rd_csr = i_io_rd && in_blk && (ofs[5:2] == 4'h0);
  // nothing may move before software has written a register
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wrote_q <= 1'b0;
    end else if (i_io_wr && in_blk) begin
      wrote_q <= 1'b1;
    end
  end
  property p_hit_decode;
    o_io_hit == ((i_io_rd || i_io_wr) && in_blk);
  endproperty
  a_hit_decode: assert property (p_hit_decode) else $error("io hit decode wrong");
  property p_csr_fixed;
    rd_csr |=> o_io_rdata[4] && o_io_rdata[3:1] == 3'h0 && !o_io_rdata[7]
      && o_io_rdata[15:9] == 7'h00 && o_io_rdata[31:27] == 5'h00 && !o_io_rdata[24];
  endproperty
  a_csr_fixed: assert property (p_csr_fixed) else $error("csr fixed bits wrong");
  property p_rsvd_zero;
    i_io_rd && in_blk && (ofs[5:2] == 4'h4 || ofs[5:2] == 4'h7) |=> o_io_rdata == 32'h0000_0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved word not zero");
  property p_quiet;
    !wrote_q |-> !o_mem.valid && !o_sc_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("activity before setup");
  property p_mem_hold;
    o_mem.valid && !i_mem_ack && !i_mem_target_abort && !i_mem_master_abort
      |=> o_mem.valid && $stable(o_mem);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("bus request dropped");
  property p_wback;
    o_mem.valid && o_mem.we |-> o_mem.be == 4'h8 && o_mem.wdata[31]
      && o_mem.wdata[29:27] == 3'h0 && !(o_mem.wdata[30] && o_mem.wdata[25]);
  endproperty
  a_wback: assert property (p_wback) else $error("status write malformed");
  property p_pulse_eof;
    o_sc_valid && o_sc_byte.pulse |-> o_sc_byte.eof;
  endproperty
  a_pulse_eof: assert property (p_pulse_eof) else $error("pulse off frame end");
  property p_sc_hold;
    o_sc_valid && !i_sc_ready |=> o_sc_valid && $stable(o_sc_byte);
  endproperty
  a_sc_hold: assert property (p_sc_hold) else $error("stalled byte changed");
  property p_irq_or;
    rd_csr |=> (o_io_rdata[6] && (|{o_io_rdata[26:25], o_io_rdata[23], o_io_rdata[21:19]}))
      == $past(o_sc_irq);
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not masked or of flags");
  c_wback: cover property (o_mem.valid && o_mem.we && i_mem_ack);
  c_eof_byte: cover property (o_sc_valid && i_sc_ready && o_sc_byte.eof);
  c_irq: cover property (o_sc_irq);
endmodule : irtx_dma_properties

bind irtx_dma irtx_dma_properties u_props (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
  .i_io_base(i_io_base), .i_io_addr(i_io_addr), .i_io_rd(i_io_rd), .i_io_wr(i_io_wr),
  .i_io_be(i_io_be), .i_io_wdata(i_io_wdata), .o_io_hit(o_io_hit), .o_io_rdata(o_io_rdata),
  .o_mem(o_mem), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
  .i_mem_target_abort(i_mem_target_abort), .i_mem_master_abort(i_mem_master_abort),
  .o_sc_valid(o_sc_valid), .i_sc_ready(i_sc_ready), .o_sc_byte(o_sc_byte), .o_sc_irq(o_sc_irq));

// ==== tb/irtx_mem_model.sv ====
// host memory answering the channel's bus master requests
`timescale 1ns/1ps
module irtx_mem_model (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire irtx_pkg::irtx_mem_req_s i_mem,
  input wire logic [1:0] i_lat,
  input wire logic [1:0] i_abort,
  output logic o_ack,
  output logic [31:0] o_rdata,
  output logic o_pci_target_abort_flag,
  output logic o_pci_master_abort_flag
);
  logic [31:0] mem [0:63];
  logic [1:0] wait_q;
  logic busy;
  assign busy = o_ack | o_pci_target_abort_flag | o_pci_master_abort_flag;
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      {o_ack, o_pci_target_abort_flag, o_pci_master_abort_flag, wait_q} <= '0;
      o_rdata <= '0;
    end else begin
      {o_ack, o_pci_target_abort_flag, o_pci_master_abort_flag} <= '0;
      // released data wanders so a late sample cannot pass by luck
      o_rdata <= ~o_rdata;
      if (i_mem.valid && !busy) begin
        if (wait_q != i_lat) begin
          wait_q <= wait_q + 2'd1;
        end else begin
          wait_q <= '0;
          if (i_abort == 2'd1) begin
            o_pci_target_abort_flag <= 1'b1;
          end else if (i_abort == 2'd2) begin
            o_pci_master_abort_flag <= 1'b1;
          end else begin
            o_ack <= 1'b1;
            if (!i_mem.we) begin
              o_rdata <= mem[i_mem.addr[7:2]];
            end
            for (int b = 0; b < 4; b++) begin
              if (i_mem.we && i_mem.be[b]) begin
                mem[i_mem.addr[7:2]][8*b +: 8] <= i_mem.wdata[8*b +: 8];
              end
            end
          end
        end
      end
    end
  end
endmodule : irtx_mem_model

// ==== tb/tb_irtx_dma.sv ====
// self-checking bench for the transmit dma channel
`timescale 1ns/1ps
module tb_irtx_dma;
  localparam logic [31:0] BASE = 32'h0000_1000;
  logic i_mclk, i_sys_rst, i_io_rd, i_io_wr, o_io_hit, i_sc_ready, o_sc_valid, o_sc_irq;
  logic [31:0] i_io_addr, i_io_wdata, o_io_rdata, mem_rdata, d;
  logic [3:0] i_io_be;
  logic ack, pci_target_abort_flag, pci_master_abort_flag, stall;
  logic [1:0] lat, abort;
  irtx_pkg::irtx_mem_req_s o_mem;
  irtx_pkg::irtx_byte_s o_sc_byte;
  logic [9:0] expq[$];
  int fails, compares, seed, r, j;
  irtx_dma dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_io_base(BASE), .i_io_addr(i_io_addr),
    .i_io_rd(i_io_rd), .i_io_wr(i_io_wr), .i_io_be(i_io_be), .i_io_wdata(i_io_wdata),
    .o_io_hit(o_io_hit), .o_io_rdata(o_io_rdata), .o_mem(o_mem), .i_mem_ack(ack),
    .i_mem_rdata(mem_rdata), .i_mem_target_abort(pci_target_abort_flag), .i_mem_master_abort(pci_master_abort_flag),
    .o_sc_valid(o_sc_valid), .i_sc_ready(i_sc_ready), .o_sc_byte(o_sc_byte), .o_sc_irq(o_sc_irq));
  irtx_mem_model u_mem (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_mem(o_mem), .i_lat(lat),
    .i_abort(abort), .o_ack(ack), .o_rdata(mem_rdata), .o_pci_target_abort_flag(pci_target_abort_flag), .o_pci_master_abort_flag(pci_master_abort_flag));
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [5:0] ofs, input logic [31:0] v, input logic [3:0] be);
    @(posedge i_mclk);
    #1 i_io_addr = BASE + 32'(ofs);
    i_io_wdata = v;
    i_io_be = be;
    i_io_wr = 1'b1;
    @(posedge i_mclk);
    #1 i_io_wr = 1'b0;
  endtask : wr
  task automatic rck(input string name, input logic [5:0] ofs, input logic [31:0] exp);
    @(posedge i_mclk);
    #1 i_io_addr = BASE + 32'(ofs);
    i_io_rd = 1'b1;
    @(posedge i_mclk);
    #1 i_io_rd = 1'b0;
    d = o_io_rdata;
    if (name != "") chk(name, d, exp);
  endtask : rck
  // descriptor in the table at 0x40, expected bytes queued for the stream
  task automatic desc(input int i, input int ptr, input int len, input logic [7:0] cmd,
                      input bit push);
    u_mem.mem[16 + 2 * i] = ptr;
    u_mem.mem[17 + 2 * i] = {cmd, 8'h00, 16'(len)};
    for (int k = 0; push && k < len; k++) begin
      expq.push_back({cmd[6] && k == len - 1, cmd[1] && cmd[6] && k == len - 1,
                      u_mem.mem[(ptr + k) / 4][8 * ((ptr + k) % 4) +: 8]});
    end
  endtask : desc
  // poll the csr until bit b sets, then let the stream drain
  task automatic poll(input int b, input logic [31:0] exp);
    int t;
    d = '0;
    // ready held low at first so the fifo fills and refuses
    for (t = 0; t < 400 && d[b] !== 1'b1; t++) begin
      if (t == 20) stall = 1'b0;
      rck("", 6'h00, 32'h0);
    end
    stall = 1'b0;
    for (t = 0; t < 50 && o_sc_valid !== 1'b0; t++) @(posedge i_mclk);
    if (d[b] !== 1'b1 || o_sc_valid !== 1'b0) begin
      fails++;
      give_verdict();
    end
    chk("csr end", d, exp);
  endtask : poll
  task automatic run(input logic [7:0] n, input logic [31:0] csr, input int b,
                     input logic [31:0] exp);
    wr(6'h08, 32'h0000_0040, 4'hf);
    rck("table base", 6'h08, 32'h0000_0040);
    wr(6'h04, {24'h00_0000, n}, 4'h1);
    stall = 1'b1;
    wr(6'h00, csr, 4'hf);
    poll(b, exp);
  endtask : run
  always @(posedge i_mclk) begin
    if (i_sys_rst === 1'b0 && o_sc_valid === 1'b1 && i_sc_ready) begin
      chk("stream byte", {22'h0, o_sc_byte}, {22'h0, expq.pop_front()});
    end
    r = $random(seed);
    #1 i_sc_ready = !stall && r[0];
  end
  initial begin
    seed = 32'h3c0d_8bcb;
    {i_sys_rst, i_io_rd, i_io_wr, stall, i_sc_ready} = 5'b10010;
    i_io_addr = BASE;
    i_io_wdata = '0;
    i_io_be = '0;
    lat = 2'd2;
    abort = 2'd0;
    repeat (16) @(posedge i_mclk);
    #1 i_sys_rst = 1'b0;
    rck("csr reset", 6'h00, 32'h0000_0010);
    for (j = 1; j < 16; j++) rck("word reset", 6'(4 * j), 32'h0);
    @(posedge i_mclk);
    #1 i_io_addr = BASE + 32'h0000_0040;
    i_io_rd = 1'b1;
    #2 chk("hit outside", {31'h0, o_io_hit}, 32'h0);
    @(posedge i_mclk);
    #1 i_io_rd = 1'b0;
    for (j = 32; j < 40; j++) u_mem.mem[j] = $random(seed);
    desc(0, 32'h80, 6, 8'h01, 1'b1);
    desc(1, 32'h93, 3, 8'h42, 1'b1);
    run(8'd2, 32'h0000_0041, 16, 32'h0029_0051);
    rck("count", 6'h04, 32'h0);
    chk("irq", {31'h0, o_sc_irq}, 32'h1);
    chk("left over", 32'(expq.size()), 32'h0);
    // underrun depends on stream timing, so its bit is masked
    chk("status 0", u_mem.mem[17] & 32'hfb00_0000, 32'h8100_0000);
    chk("status 1", u_mem.mem[19] & 32'hfb00_0000, 32'hc000_0000);
    rck("", 6'h14, 32'h0);
    chk("len word", d & 32'hfbff_ffff, 32'hc000_0000);
    wr(6'h00, 32'h06b9_0000, 4'hf);
    rck("csr cleared", 6'h00, 32'h0000_0010);
    for (j = 1; j < 4; j++) begin
      abort = (j == 3) ? 2'd0 : 2'(j);
      desc(0, 32'h80, 2, (j == 3) ? 8'h48 : 8'h40, 1'b0);
      run(8'd1, 32'h0000_0041, 16,
          (j == 3) ? 32'h0081_0051 : 32'h0001_0051 | (32'h0100_0000 << j));
      wr(6'h00, 32'h06b9_0000, 4'hf);
    end
    // pause after the first frame, then resume to the end of the table
    desc(0, 32'h88, 2, 8'h40, 1'b1);
    desc(1, 32'h8c, 1, 8'h42, 1'b1);
    run(8'd2, 32'h0000_0141, 18, 32'h000e_0151);
    wr(6'h00, 32'h0000_0041, 4'hf);
    poll(16, 32'h0029_0051);
    chk("pause left over", 32'(expq.size()), 32'h0);
    wr(6'h00, 32'h06b9_0000, 4'hf);
    wr(6'h18, 32'h0005_0000, 4'hc);
    rck("timer written", 6'h18, 32'h0005_0000);
    wr(6'h00, 32'h0000_0020, 4'hf);
    repeat (10) @(posedge i_mclk);
    rck("timer live", 6'h18, 32'h0);
    rck("csr timeout", 6'h00, 32'h0010_0030);
    chk("irq masked", {31'h0, o_sc_irq}, 32'h0);
    wr(6'h00, 32'h0010_0000, 4'hf);
    rck("timer held", 6'h18, 32'h0005_0000);
    rck("csr final", 6'h00, 32'h0000_0010);
    give_verdict();
  end
endmodule : tb_irtx_dma
